// ==== design/regulator_pkg.sv ====
package regulator_pkg;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;
    localparam logic [7:0] CTRL_OFFSET = 8'h00;
    localparam logic [7:0] IRQ_CTRL_OFFSET = 8'h04;
    localparam logic [7:0] EVT_STATUS_OFFSET = 8'h08;
    localparam logic [7:0] EVT_MASK_OFFSET = 8'h0c;
    localparam int unsigned OFF_BIT = 7;
    localparam int unsigned LEVEL_BIT = 6;
    localparam int unsigned POL_BIT = 5;
    localparam int unsigned LOWPWR_BIT = 4;
    localparam int unsigned IRQ_EN_BIT = 0;
    localparam int unsigned RST_SRC_BIT = 1;
    localparam int unsigned EVT_RISE_BIT = 0;
    localparam int unsigned EVT_FALL_BIT = 1;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] CTRL_WMASK = 8'hb0;
    localparam logic [7:0] IRQ_CTRL_WMASK = 8'h03;
    localparam logic [7:0] EVT_WMASK = 8'h03;
    localparam int unsigned SYNC_STAGES = 2;

    typedef enum logic [1:0] {
        MODE_NORMAL,
        MODE_LOWPWR,
        MODE_OFF
    } reg_mode_t;

    function automatic logic sel_match(input logic level, input logic pol);
        sel_match = (level == pol);
    endfunction
endpackage

// ==== design/vbus_sync.sv ====
`timescale 1ns/1ps
module vbus_sync
    import regulator_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic async_i,
    output logic sync_o
);
    logic [SYNC_STAGES-1:0] stage_reg;

    // The first stage feeds only the second stage.
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            stage_reg <= '0;
        end else begin
            stage_reg <= {stage_reg[SYNC_STAGES-2:0], async_i};
        end
    end

    assign sync_o = stage_reg[SYNC_STAGES-1];
endmodule // vbus_sync

// ==== design/edge_detect.sv ====
`timescale 1ns/1ps
module edge_detect (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic level_i,
    output logic rise_o,
    output logic fall_o
);
    logic prev_reg;

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            prev_reg <= 1'b0;
        end else begin
            prev_reg <= level_i;
        end
    end

    assign rise_o = level_i & ~prev_reg;
    assign fall_o = ~level_i & prev_reg;
endmodule // edge_detect

// ==== design/regulator_vbus_control.sv ====
`timescale 1ns/1ps
// Contract
// [RULE_01] Regulator stays on after every reset
// [RULE_02] Software toggles regulator with one bit
// [RULE_03] Mode bit picks normal or low power
// [RULE_04] Status bit shows live bus level
// [RULE_05] Enabled interrupt when level matches polarity
// [RULE_06] Interrupt purely level driven, no flag
// [RULE_07] Reset request when level matches polarity
// [RULE_08] Polarity zero low, one high
// [RULE_09] Bit seven disables regulator when set
// [RULE_10] Bit four selects low power mode
// [RULE_11] Low four bits read zero
// [RULE_12] Bus level passes two-stage synchronizer
module regulator_vbus_control
    import regulator_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [DATA_W-1:0] rdata_o,
    input wire logic vbus_i,
    output logic regulator_enable_o,
    output logic regulator_low_power_o,
    output logic vbus_irq_o,
    output logic vbus_reset_req_o,
    output logic event_irq_o
);
    logic vbus_sync;
    logic vbus_rise;
    logic vbus_fall;
    logic regulator_off_bit_reg;
    logic regulator_low_power_select_reg;
    logic bus_power_polarity_select_reg;
    logic irq_en_reg;
    logic rst_src_reg;
    logic [1:0] evt_status_reg;
    logic [1:0] evt_status_next;
    logic [1:0] evt_mask_reg;
    logic [DATA_W-1:0] rdata_reg;
    logic [DATA_W-1:0] rdata_next;
    logic reg_en_reg;
    logic reg_lp_reg;
    logic irq_reg;
    logic rst_req_reg;
    logic event_irq_reg;
    reg_mode_t mode;

    wire sel_ctrl = (addr_i == CTRL_OFFSET);
    wire sel_irq = (addr_i == IRQ_CTRL_OFFSET);
    wire sel_status = (addr_i == EVT_STATUS_OFFSET);
    wire sel_mask = (addr_i == EVT_MASK_OFFSET);
    wire wr_ctrl = wr_i & sel_ctrl;
    wire wr_irq = wr_i & sel_irq;
    wire wr_mask = wr_i & sel_mask;
    wire rd_status = rd_i & sel_status;
    // [RULE_08] polarity compare
    wire match = sel_match(vbus_sync, bus_power_polarity_select_reg);
    wire [1:0] evt_set = {vbus_fall, vbus_rise};

    // [RULE_12] input synchronizer
    vbus_sync u_sync (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .async_i(vbus_i),
        .sync_o(vbus_sync)
    );

    edge_detect u_edge (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .level_i(vbus_sync),
        .rise_o(vbus_rise),
        .fall_o(vbus_fall)
    );

    // [RULE_01] reset keeps on
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            regulator_off_bit_reg <= CTRL_RESET[OFF_BIT];
            regulator_low_power_select_reg <= CTRL_RESET[LOWPWR_BIT];
            bus_power_polarity_select_reg <= CTRL_RESET[POL_BIT];
        end else if (wr_ctrl) begin
            // [RULE_02] software on/off
            regulator_off_bit_reg <= wdata_i[OFF_BIT];
            // [RULE_10] mode bit four
            regulator_low_power_select_reg <= wdata_i[LOWPWR_BIT];
            bus_power_polarity_select_reg <= wdata_i[POL_BIT];
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            irq_en_reg <= 1'b0;
            rst_src_reg <= 1'b0;
            evt_mask_reg <= 2'h0;
        end else begin
            if (wr_irq) begin
                irq_en_reg <= wdata_i[IRQ_EN_BIT];
                rst_src_reg <= wdata_i[RST_SRC_BIT];
            end
            if (wr_mask) begin
                evt_mask_reg <= wdata_i[1:0];
            end
        end
    end

    // Edge events win over a clearing read in the same cycle.
    assign evt_status_next = rd_status ? evt_set : (evt_status_reg | evt_set);

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            evt_status_reg <= 2'h0;
        end else begin
            evt_status_reg <= evt_status_next;
        end
    end

    // [RULE_11] reserved read zero
    wire [DATA_W-1:0] ctrl_read = {regulator_off_bit_reg, vbus_sync, bus_power_polarity_select_reg,
                                   regulator_low_power_select_reg, 4'h0};

    always_comb begin
        rdata_next = 8'h00;
        if (rd_i) begin
            // [RULE_04] live level
            if (sel_ctrl) begin
                rdata_next = ctrl_read;
            end else if (sel_irq) begin
                rdata_next = {6'h00, rst_src_reg, irq_en_reg};
            end else if (sel_status) begin
                rdata_next = {6'h00, evt_status_reg};
            end else if (sel_mask) begin
                rdata_next = {6'h00, evt_mask_reg};
            end
        end
    end

    always_comb begin
        if (regulator_off_bit_reg) begin
            mode = MODE_OFF;
        end else if (regulator_low_power_select_reg) begin
            mode = MODE_LOWPWR;
        end else begin
            mode = MODE_NORMAL;
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_reg <= 8'h00;
            reg_en_reg <= 1'b1;
            reg_lp_reg <= 1'b0;
            irq_reg <= 1'b0;
            rst_req_reg <= 1'b0;
            event_irq_reg <= 1'b0;
        end else begin
            rdata_reg <= rdata_next;
            // [RULE_09] disable bit seven
            case (mode)
                MODE_OFF: begin
                    reg_en_reg <= 1'b0;
                    reg_lp_reg <= 1'b0;
                end
                // [RULE_03] low power mode
                MODE_LOWPWR: begin
                    reg_en_reg <= 1'b1;
                    reg_lp_reg <= 1'b1;
                end
                default: begin
                    reg_en_reg <= 1'b1;
                    reg_lp_reg <= 1'b0;
                end
            endcase
            // [RULE_05] enabled level interrupt
            // [RULE_06] no pending flag
            irq_reg <= irq_en_reg & match;
            // [RULE_07] reset on match
            rst_req_reg <= rst_src_reg & match;
            event_irq_reg <= |(evt_status_next & evt_mask_reg);
        end
    end

    assign rdata_o = rdata_reg;
    assign regulator_enable_o = reg_en_reg;
    assign regulator_low_power_o = reg_lp_reg;
    assign vbus_irq_o = irq_reg;
    assign vbus_reset_req_o = rst_req_reg;
    assign event_irq_o = event_irq_reg;

    sequence s_level_match;
        irq_en_reg && vbus_sync == bus_power_polarity_select_reg;
    endsequence

    sequence s_pin_rise_held;
        $rose(vbus_i) ##1 vbus_i [*2];
    endsequence

    sequence s_pin_fall_held;
        $fell(vbus_i) ##1 !vbus_i [*2];
    endsequence

    // [RULE_06] level follows match
    AST_IRQ_LEVEL: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [RULE_06]
        ##1 vbus_irq_o == $past(irq_en_reg && match))
        else $error("interrupt does not follow level match");

    // [RULE_05] raise on match
    AST_IRQ_RAISE: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [RULE_05]
        s_level_match |=> vbus_irq_o)
        else $error("interrupt missing while level matches");

    // [RULE_08] polarity encoding
    AST_POL_LOW: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [RULE_08]
        (irq_en_reg && !bus_power_polarity_select_reg && !vbus_sync) |=> vbus_irq_o)
        else $error("low polarity not honoured");

    // [RULE_08] high polarity quiet
    AST_POL_HIGH: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [RULE_08]
        (irq_en_reg && bus_power_polarity_select_reg && !vbus_sync) |=> !vbus_irq_o)
        else $error("high polarity fires on low level");

    // [RULE_07] reset request
    AST_RST_REQ: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [RULE_07]
        (rst_src_reg && match) |=> vbus_reset_req_o)
        else $error("reset request missing");

    // [RULE_12] two stage delay
    AST_SYNC_DELAY: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [RULE_12]
        s_pin_rise_held |-> vbus_sync)
        else $error("synchronizer latency wrong");

    // [RULE_04] status live
    AST_STATUS_LIVE: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [RULE_04]
        (rd_i && sel_ctrl) |=> rdata_o[LEVEL_BIT] == $past(vbus_sync))
        else $error("status bit not live");

    // [RULE_11] reserved zero
    AST_RSVD_ZERO: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [RULE_11]
        (rd_i && sel_ctrl) |=> rdata_o[3:0] == 4'h0)
        else $error("reserved bits not zero");

    // [RULE_09] disable takes effect
    AST_OFF: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [RULE_09]
        (wr_ctrl && wdata_i[OFF_BIT]) |=> ##1 !regulator_enable_o)
        else $error("regulator not disabled");

    // [RULE_03] low power select
    AST_LOWPWR: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [RULE_03]
        (wr_ctrl && wdata_i[LOWPWR_BIT] && !wdata_i[OFF_BIT]) |=> ##1 regulator_low_power_o && regulator_enable_o)
        else $error("low power mode not entered");

    // [RULE_01] on after reset
    AST_ON_RESET: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [RULE_01]
        $fell(regulator_enable_o) |-> $past(regulator_off_bit_reg))
        else $error("regulator dropped without software");

    // [RULE_02] re-enable
    AST_ON: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [RULE_02]
        (wr_ctrl && !wdata_i[OFF_BIT]) |=> ##1 regulator_enable_o)
        else $error("regulator not re-enabled");

    // Read data stands only in the cycle after a read.
    AST_RDATA_IDLE: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        !rd_i |=> rdata_o == 8'h00)
        else $error("read data present without a read");

    // An unmapped address reads as zero.
    AST_UNMAPPED: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (rd_i && !sel_ctrl && !sel_irq && !sel_status && !sel_mask) |=> rdata_o == 8'h00)
        else $error("unmapped read not zero");

    // Unused upper bits of the event registers read as zero.
    AST_RSVD_HIGH: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (rd_i && (sel_irq || sel_status || sel_mask)) |=> rdata_o[7:2] == 6'h00)
        else $error("unused event register bits not zero");

    // A sticky rise bit holds until the status register is read.
    AST_STICKY_RISE: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (!rd_status && evt_status_reg[EVT_RISE_BIT]) |=> evt_status_reg[EVT_RISE_BIT])
        else $error("rise bit lost without a read");

    // A sticky fall bit holds until the status register is read.
    AST_STICKY_FALL: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (!rd_status && evt_status_reg[EVT_FALL_BIT]) |=> evt_status_reg[EVT_FALL_BIT])
        else $error("fall bit lost without a read");

    // An edge in the cycle of a clearing read still sets its bit.
    AST_SET_WINS: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (rd_status && vbus_rise) |=> evt_status_reg[EVT_RISE_BIT])
        else $error("clearing read swallowed an edge");

    // A status read clears a bit that sees no new edge.
    AST_READ_CLEARS: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (rd_status && !vbus_fall) |=> !evt_status_reg[EVT_FALL_BIT])
        else $error("status read did not clear");

    // The event interrupt follows the unmasked sticky bits.
    AST_EVT_IRQ_LEVEL: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        event_irq_o == (|(evt_status_reg & $past(evt_mask_reg))))
        else $error("event interrupt does not follow status");

    // [RULE_07] request drops
    AST_RST_REQ_DROP: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [RULE_07]
        !(rst_src_reg && match) |=> !vbus_reset_req_o)
        else $error("reset request without match");

    // [RULE_05] disabled stays quiet
    AST_IRQ_OFF: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [RULE_05]
        !irq_en_reg |=> !vbus_irq_o)
        else $error("interrupt while disabled");

    // [RULE_06] drops without match
    AST_IRQ_DROP: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [RULE_06]
        (irq_en_reg && !match) |=> !vbus_irq_o)
        else $error("interrupt held after level left polarity");

    // [RULE_10] normal mode select
    AST_NORMAL_MODE: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [RULE_10]
        (wr_ctrl && !wdata_i[LOWPWR_BIT] && !wdata_i[OFF_BIT]) |=> ##1 regulator_enable_o && !regulator_low_power_o)
        else $error("normal mode not entered");

    // [RULE_12] falling pin latency
    AST_SYNC_FALL: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [RULE_12]
        s_pin_fall_held |-> !vbus_sync)
        else $error("synchronizer fall latency wrong");

    // A rising synchronised level sets the rise bit.
    AST_RISE_EVENT: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        $rose(vbus_sync) |=> evt_status_reg[EVT_RISE_BIT])
        else $error("rise event not recorded");

    // A falling synchronised level sets the fall bit.
    AST_FALL_EVENT: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        $fell(vbus_sync) |=> evt_status_reg[EVT_FALL_BIT])
        else $error("fall event not recorded");

    // [RULE_08] high polarity fires
    AST_POL_HIGH_ON: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [RULE_08]
        (irq_en_reg && bus_power_polarity_select_reg && vbus_sync) |=> vbus_irq_o)
        else $error("high polarity not honoured");

    // [RULE_01] enable holds unwritten
    AST_ENABLE_HOLD: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [RULE_01]
        (!wr_ctrl ##2 1'b1) |-> $stable(regulator_enable_o))
        else $error("regulator enable changed without a write");

    // [RULE_03] low power only on
    AST_LP_ONLY_ON: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [RULE_03]
        regulator_low_power_o |-> regulator_enable_o)
        else $error("low power shown while regulator off");
endmodule // regulator_vbus_control

// ==== sim/vbus_line_model.sv ====
`timescale 1ns/1ps
// The host side of the bus power line; it only ever shows a level.
module vbus_line_model (
    input wire logic present_i,
    output logic vbus_o
);
    assign vbus_o = present_i;
endmodule // vbus_line_model

// ==== sim/regulator_vbus_control_bench.sv ====
`timescale 1ns/1ps
module regulator_vbus_control_bench;
    import regulator_pkg::*;
    logic sys_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] addr_i = 8'h00;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic present = 1'b0;
    logic vbus_i;
    logic [7:0] rdata_o;
    logic regulator_enable_o, regulator_low_power_o, vbus_irq_o, vbus_reset_req_o, event_irq_o;
    int mismatches = 0;
    int cmp_count = 0;
    logic [7:0] v;
    logic e1, e2;

    always #2.5 sys_clk_i = ~sys_clk_i;

    vbus_line_model i_line (.present_i(present), .vbus_o(vbus_i));
    regulator_vbus_control i_dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .vbus_i(vbus_i), .regulator_enable_o(regulator_enable_o),
        .regulator_low_power_o(regulator_low_power_o), .vbus_irq_o(vbus_irq_o),
        .vbus_reset_req_o(vbus_reset_req_o), .event_irq_o(event_irq_o));

    task automatic final_report();
        $display("checks %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge sys_clk_i);
        wr_i <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge sys_clk_i);
        rd_i <= 1'b0;
        #1;
        d = rdata_o;
    endtask

    task automatic set_vbus(input logic b);
        @(posedge sys_clk_i);
        present <= b;
    endtask

    task automatic t_reset();
        chk("enable", 8'h01, {7'h0, regulator_enable_o});
        chk("low_power", 8'h00, {7'h0, regulator_low_power_o});
        rd(CTRL_OFFSET, v);
        chk("ctrl", 8'h00, v);
    endtask

    task automatic t_control();
        wr(CTRL_OFFSET, 8'hf0);
        wait_cyc(2);
        chk("enable off", 8'h00, {7'h0, regulator_enable_o});
        rd(CTRL_OFFSET, v);
        chk("ctrl reserved", 8'hb0, v);
        wait_cyc(1);
        chk("rdata idle", 8'h00, rdata_o);
        wr(CTRL_OFFSET, 8'h10);
        wait_cyc(2);
        chk("enable on", 8'h01, {7'h0, regulator_enable_o});
        chk("low power", 8'h01, {7'h0, regulator_low_power_o});
        wr(CTRL_OFFSET, 8'h80);
        wait_cyc(2);
        chk("enable off again", 8'h00, {7'h0, regulator_enable_o});
        chk("low power off", 8'h00, {7'h0, regulator_low_power_o});
        rst_i <= 1'b1;
        wait_cyc(2);
        rst_i <= 1'b0;
        wait_cyc(1);
        chk("enable after reset", 8'h01, {7'h0, regulator_enable_o});
        rd(8'h10, v);
        chk("unmapped", 8'h00, v);
    endtask

    task automatic t_level();
        for (int b = 0; b < 2; b++) begin
            set_vbus(b[0]);
            wait_cyc(4);
            rd(CTRL_OFFSET, v);
            chk("live level", {1'b0, b[0], 6'h00}, v);
        end
    endtask

    // Irq-control settings 0 to 2 against both polarities and both levels.
    task automatic t_irq();
        logic [7:0] mode;
        logic m;
        for (int k = 0; k < 3; k++) begin
            mode = k[7:0];
            wr(IRQ_CTRL_OFFSET, mode);
            for (int p = 0; p < 4; p++) begin
                wr(CTRL_OFFSET, {2'b00, p[1], 5'h00});
                set_vbus(p[0]);
                wait_cyc(3);
                m = (p[0] == p[1]);
                chk("vbus irq", {7'h0, mode[0] & m}, {7'h0, vbus_irq_o});
                chk("reset req", {7'h0, mode[1] & m}, {7'h0, vbus_reset_req_o});
            end
        end
        wr(IRQ_CTRL_OFFSET, 8'h00);
    endtask

    task automatic t_event();
        set_vbus(1'b0);
        wait_cyc(6);
        rd(EVT_STATUS_OFFSET, v);
        wr(EVT_MASK_OFFSET, 8'h03);
        rd(EVT_MASK_OFFSET, v);
        chk("mask", 8'h03, v);
        set_vbus(1'b1);
        wait_cyc(5);
        e1 = event_irq_o;
        rd(EVT_STATUS_OFFSET, v);
        chk("rise sticky", 8'h01, v);
        wait_cyc(2);
        chk("event cleared", 8'h00, {7'h0, event_irq_o});
        wr(EVT_MASK_OFFSET, 8'h00);
        set_vbus(1'b0);
        wait_cyc(5);
        e2 = event_irq_o;
        rd(EVT_STATUS_OFFSET, v);
        chk("fall sticky", 8'h02, v);
        chk("event raised", 8'h01, {7'h0, e1});
        chk("event masked", 8'h00, {7'h0, e2});
        chk("mask effect", 8'h01, {7'h0, e1 ^ e2});
    endtask

    initial begin
        repeat (5) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        wait_cyc(1);
        t_reset();
        t_control();
        t_level();
        t_irq();
        t_event();
        final_report();
    end

    initial begin
        repeat (20000) @(posedge sys_clk_i);
        mismatches++;
        final_report();
    end
endmodule // regulator_vbus_control_bench
